// ### logic/pds_diag_engine.sv
// one port's cable diagnostic sequencer with result capture and timeout
`timescale 1ns/1ns
`default_nettype none
module pds_diag_engine #(
  parameter int TIMEOUT_CYC = pds_pkg::DIAG_TIMEOUT_CYC
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic start,
  input wire logic ana_done,
  input wire logic [1:0] ana_result,
  input wire logic ana_short,
  input wire logic [8:0] ana_count,
  output logic busy,
  output logic ana_req,
  output pds_pkg::pds_result_e result,
  output logic short_within_ten_m,
  output logic [8:0] fault_count,
  output logic done_pulse
);

  localparam int CNT_W = $clog2(TIMEOUT_CYC + 1);
  localparam logic [CNT_W-1:0] CNT_LAST = CNT_W'(TIMEOUT_CYC - 1);

  pds_pkg::pds_diag_state_e state_reg;
  logic [CNT_W-1:0] tmo_reg;
  logic timed_out;
  logic idle_like;

  assign timed_out = (tmo_reg == CNT_LAST);
  // the finish cycle takes a launch as well, so a start right after completion is not lost
  assign idle_like = (state_reg == pds_pkg::PDS_DG_IDLE) || (state_reg == pds_pkg::PDS_DG_FINISH);

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      state_reg <= pds_pkg::PDS_DG_IDLE;
    else
      case (state_reg)
        pds_pkg::PDS_DG_IDLE:
          if (start)
            state_reg <= pds_pkg::PDS_DG_RUN;
        pds_pkg::PDS_DG_RUN:
          if (ana_done || timed_out)
            state_reg <= pds_pkg::PDS_DG_FINISH;
        pds_pkg::PDS_DG_FINISH:
          state_reg <= start ? pds_pkg::PDS_DG_RUN : pds_pkg::PDS_DG_IDLE;
        default:
          state_reg <= pds_pkg::PDS_DG_IDLE;
      endcase
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      tmo_reg <= '0;
    else if (state_reg == pds_pkg::PDS_DG_RUN)
      tmo_reg <= tmo_reg + CNT_W'(1);
    else
      tmo_reg <= '0;
  end

  // results land in the same edge that busy drops, so a zero start bit means valid data
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      result <= pds_pkg::CD_RES_RST;
      short_within_ten_m <= 1'b0;
      fault_count <= pds_pkg::CD_CNT_RST;
    end
    else if (state_reg == pds_pkg::PDS_DG_RUN && ana_done)
    begin
      result <= pds_pkg::pds_result_e'(ana_result); // [RQ4]
      short_within_ten_m <= ana_short; // [RQ5]
      fault_count <= ana_count; // [RQ6]
    end
    else if (state_reg == pds_pkg::PDS_DG_RUN && timed_out)
    begin
      result <= pds_pkg::PDS_RES_FAIL; // [RQ4]
      short_within_ten_m <= 1'b0;
      fault_count <= pds_pkg::CD_CNT_RST;
    end
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      busy <= 1'b0;
      ana_req <= 1'b0;
      done_pulse <= 1'b0;
    end
    else
    begin
      busy <= idle_like ? start
            : (state_reg == pds_pkg::PDS_DG_RUN) ? !(ana_done || timed_out) : 1'b0; // [RQ2] [RQ3]
      ana_req <= idle_like ? start
               : (state_reg == pds_pkg::PDS_DG_RUN) && !(ana_done || timed_out);
      done_pulse <= (state_reg == pds_pkg::PDS_DG_RUN) && (ana_done || timed_out);
    end
  end

endmodule // pds_diag_engine
`default_nettype wire

// ### logic/pds_phy_regs.sv
// per-port PHY diagnostic, partner ability and special control register bank
//
// Behaviour
// RQ1 - partner ability bits 8..5 report the partner's 100FD, 100HD, 10FD, 10HD, read-only, reset 0.
// RQ2 - writing one to cable test bit 15 launches a diagnostic, and the bit self-clears when done.
// RQ3 - once the start bit reads zero after a launch, every result field is final and valid.
// RQ4 - bits 14-13 give the outcome: 00 normal, 01 open, 10 short, 11 test failed, reset 00.
// RQ5 - read-only bit 12 is set when a detected short lies closer than 10 meters.
// RQ6 - bits 8-0 hold the nine-bit fault distance count of about 0.4 m per step, reset 0.
// RQ7 - special status bit 5 is set while receive polarity is reversed, meaningful at 10 Mb/s.
// RQ8 - special bit 2 at zero enables power saving and at one disables it, reset 1.
// RQ9 - special bit 1 loops the port's receive pair back to its transmit pair at PMD/PMA.
// RQ10 - port 1 loopback storage is also switch reg 26 bit 1, port 2 is reg 42 bit 1; here loop_reg is reached only through the special register.
// RQ11 - the partner ability register decodes at PHY register index 0x5 of each port.
// RQ12 - writes to read-only and reserved fields are ignored, and reserved fields read zero.
// RQ13 - special bit 3 at one forces link pass, at zero restores normal detection, reset 0.
//
// Implementation choice: strobed register access.
`timescale 1ns/1ns
`default_nettype none
module pds_phy_regs #(
  parameter int NUM_PORTS = pds_pkg::NUM_PORTS,
  parameter int DIAG_TIMEOUT_CYC = pds_pkg::DIAG_TIMEOUT_CYC
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [pds_pkg::ADDR_W-1:0] reg_addr,
  input wire logic [pds_pkg::DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [pds_pkg::DATA_W-1:0] reg_rdata,
  input wire logic [NUM_PORTS*pds_pkg::LPA_W-1:0] partner_ability_in,
  input wire logic [NUM_PORTS-1:0] polarity_reversed_in,
  input wire logic [NUM_PORTS-1:0] mdi_mode_in,
  input wire logic [NUM_PORTS-1:0] diag_ana_done,
  input wire logic [NUM_PORTS*2-1:0] diag_ana_result,
  input wire logic [NUM_PORTS-1:0] diag_ana_short,
  input wire logic [NUM_PORTS*9-1:0] diag_ana_count,
  output logic [NUM_PORTS-1:0] diag_ana_req,
  output logic [NUM_PORTS-1:0] force_link_pass,
  output logic [NUM_PORTS-1:0] power_save_en,
  output logic [NUM_PORTS-1:0] remote_loopback,
  output logic irq
);

  localparam int PW = (NUM_PORTS > 1) ? $clog2(NUM_PORTS) : 1;

  // address decode
  logic is_global;
  logic [PW-1:0] port_sel;
  logic [pds_pkg::IDX_W-1:0] reg_idx;
  logic port_ok;

  assign is_global = reg_addr[pds_pkg::ADDR_GLOBAL_BIT];
  assign port_sel = PW'(reg_addr[pds_pkg::ADDR_PORT_BIT]);
  assign reg_idx = reg_addr[pds_pkg::IDX_W-1:0];
  assign port_ok = !is_global && (32'(port_sel) < NUM_PORTS);

  // per-port state
  logic [pds_pkg::LPA_W-1:0] lpa_reg [NUM_PORTS];
  logic [NUM_PORTS-1:0] pol_reg;
  logic [NUM_PORTS-1:0] mdi_reg;
  logic [NUM_PORTS-1:0] force_reg;
  logic [NUM_PORTS-1:0] pwrsave_off_reg;
  logic [NUM_PORTS-1:0] loop_reg;
  logic [NUM_PORTS-1:0] diag_start;
  logic [NUM_PORTS-1:0] diag_busy;
  logic [NUM_PORTS-1:0] diag_done;
  logic [NUM_PORTS-1:0] diag_short;
  pds_pkg::pds_result_e diag_result [NUM_PORTS];
  logic [8:0] diag_count [NUM_PORTS];

  // interrupt state
  logic [pds_pkg::IRQ_W-1:0] irq_status_reg;
  logic [pds_pkg::IRQ_W-1:0] irq_status_next;
  logic [pds_pkg::IRQ_W-1:0] irq_mask_reg;
  logic [pds_pkg::IRQ_W-1:0] irq_events;
  logic status_read;

  genvar gp;
  generate
    for (gp = 0; gp < NUM_PORTS; gp++)
    begin : g_port
      logic sel_wr;

      assign sel_wr = reg_wr && port_ok && (32'(port_sel) == gp);

      // partner ability and status inputs sampled each cycle
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          lpa_reg[gp] <= pds_pkg::LPA_RST;
          pol_reg[gp] <= 1'b0;
          mdi_reg[gp] <= 1'b0;
        end
        else
        begin
          lpa_reg[gp] <= partner_ability_in[gp*pds_pkg::LPA_W +: pds_pkg::LPA_W]; // [RQ1]
          pol_reg[gp] <= polarity_reversed_in[gp]; // [RQ7]
          mdi_reg[gp] <= mdi_mode_in[gp];
        end
      end

      // special control bits: only the writable fields take write data
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
        begin
          force_reg[gp] <= pds_pkg::SP_FORCE_RST;
          pwrsave_off_reg[gp] <= pds_pkg::SP_PWRSAVE_OFF_RST;
          loop_reg[gp] <= pds_pkg::SP_RLOOP_RST;
        end
        else if (sel_wr && reg_idx == pds_pkg::REG_SPECIAL)
        begin
          force_reg[gp] <= reg_wdata[pds_pkg::SP_FORCE]; // [RQ13]
          pwrsave_off_reg[gp] <= reg_wdata[pds_pkg::SP_PWRSAVE_OFF]; // [RQ8]
          loop_reg[gp] <= reg_wdata[pds_pkg::SP_RLOOP]; // [RQ9] [RQ10] [RQ12]
        end
      end

      // a one written while idle launches; a write while busy or a zero does nothing
      assign diag_start[gp] = sel_wr && reg_idx == pds_pkg::REG_CABLE_DIAG
                            && reg_wdata[pds_pkg::CD_START] && !diag_busy[gp]; // [RQ2]

      pds_diag_engine #(
        .TIMEOUT_CYC(DIAG_TIMEOUT_CYC)
      ) u_diag (
        .core_clk(core_clk),
        .resetn(resetn),
        .start(diag_start[gp]),
        .ana_done(diag_ana_done[gp]),
        .ana_result(diag_ana_result[gp*2 +: 2]),
        .ana_short(diag_ana_short[gp]),
        .ana_count(diag_ana_count[gp*9 +: 9]),
        .busy(diag_busy[gp]),
        .ana_req(diag_ana_req[gp]),
        .result(diag_result[gp]),
        .short_within_ten_m(diag_short[gp]),
        .fault_count(diag_count[gp]),
        .done_pulse(diag_done[gp])
      );

      // polarity change event for the interrupt status
      logic pol_prev_reg;
      always_ff @(posedge core_clk or negedge resetn)
      begin
        if (!resetn)
          pol_prev_reg <= 1'b0;
        else
          pol_prev_reg <= pol_reg[gp];
      end

      assign irq_events[pds_pkg::IRQ_DONE_LO + gp] = diag_done[gp];
      assign irq_events[pds_pkg::IRQ_POL_LO + gp] = pol_prev_reg ^ pol_reg[gp];
    end
  endgenerate

  // control outputs registered from the stored bits, power save from the inverted off bit
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
    begin
      force_link_pass <= '0;
      power_save_en <= '0;
      remote_loopback <= '0;
    end
    else
    begin
      force_link_pass <= force_reg; // [RQ13]
      power_save_en <= ~pwrsave_off_reg; // [RQ8]
      remote_loopback <= loop_reg; // [RQ9] [RQ10]
    end
  end

  // read mux: reserved fields and unmapped addresses read zero
  logic [pds_pkg::DATA_W-1:0] rd_mux;
  always_comb
  begin
    rd_mux = '0;
    if (is_global)
    begin
      if (reg_addr == pds_pkg::GLB_IRQ_STATUS)
        rd_mux[pds_pkg::IRQ_W-1:0] = irq_status_reg;
      else if (reg_addr == pds_pkg::GLB_IRQ_MASK)
        rd_mux[pds_pkg::IRQ_W-1:0] = irq_mask_reg;
    end
    else if (port_ok)
    begin
      case (reg_idx)
        pds_pkg::REG_PARTNER_ABILITY: // [RQ11]
          rd_mux[pds_pkg::LPA_LO +: pds_pkg::LPA_W] = lpa_reg[port_sel]; // [RQ1] [RQ12]
        pds_pkg::REG_CABLE_DIAG:
        begin
          rd_mux[pds_pkg::CD_START] = diag_busy[port_sel]; // [RQ2] [RQ3]
          rd_mux[pds_pkg::CD_RES_LO +: 2] = diag_result[port_sel]; // [RQ4]
          rd_mux[pds_pkg::CD_SHORT] = diag_short[port_sel]; // [RQ5]
          rd_mux[pds_pkg::CD_CNT_LO +: pds_pkg::CD_CNT_W] = diag_count[port_sel]; // [RQ6]
        end
        pds_pkg::REG_SPECIAL:
        begin
          rd_mux[pds_pkg::SP_POLRVS] = pol_reg[port_sel]; // [RQ7]
          rd_mux[pds_pkg::SP_MDI] = mdi_reg[port_sel];
          rd_mux[pds_pkg::SP_FORCE] = force_reg[port_sel];
          rd_mux[pds_pkg::SP_PWRSAVE_OFF] = pwrsave_off_reg[port_sel];
          rd_mux[pds_pkg::SP_RLOOP] = loop_reg[port_sel];
        end
        default:
          rd_mux = '0; // [RQ12]
      endcase
    end
  end

  // read data stands only in the cycle after the strobe
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      reg_rdata <= '0;
    else if (reg_rd)
      reg_rdata <= rd_mux;
    else
      reg_rdata <= '0;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_mask_reg <= pds_pkg::IRQ_MASK_RST;
    else if (reg_wr && reg_addr == pds_pkg::GLB_IRQ_MASK)
      irq_mask_reg <= reg_wdata[pds_pkg::IRQ_W-1:0];
  end

  // read clears the sticky bits; an event in the same cycle wins
  assign status_read = reg_rd && reg_addr == pds_pkg::GLB_IRQ_STATUS;

  always_comb
  begin
    irq_status_next = irq_status_reg;
    if (status_read)
      irq_status_next = '0;
    irq_status_next = irq_status_next | irq_events;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq_status_reg <= '0;
    else
      irq_status_reg <= irq_status_next;
  end

  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      irq <= 1'b0;
    else
      irq <= |(irq_status_next & irq_mask_reg);
  end

endmodule // pds_phy_regs
`default_nettype wire

// ### logic/pds_pkg.sv
// constants and types shared by the PHY diagnostic and status register block
package pds_pkg;

  localparam int NUM_PORTS = 2;
  localparam int ADDR_W = 7;
  localparam int DATA_W = 16;
  localparam int IDX_W = 5;

  // address layout: bit 6 selects the global block, bit 5 selects the port
  localparam int ADDR_GLOBAL_BIT = 6;
  localparam int ADDR_PORT_BIT = 5;

  // per-port PHY register indices
  localparam logic [4:0] REG_PARTNER_ABILITY = 5'h05;
  localparam logic [4:0] REG_CABLE_DIAG = 5'h1D;
  localparam logic [4:0] REG_SPECIAL = 5'h1F;

  // global registers
  localparam logic [6:0] GLB_IRQ_STATUS = 7'h40;
  localparam logic [6:0] GLB_IRQ_MASK = 7'h41;

  // partner ability field: 100 full at 8 down to 10 half at 5
  localparam int LPA_LO = 5;
  localparam int LPA_W = 4;
  localparam logic [3:0] LPA_RST = 4'h0;

  // cable diagnostic register fields
  localparam int CD_START = 15;
  localparam int CD_RES_LO = 13;
  localparam int CD_SHORT = 12;
  localparam int CD_CNT_LO = 0;
  localparam int CD_CNT_W = 9;
  localparam logic [8:0] CD_CNT_RST = 9'h000;

  // special control/status fields
  localparam int SP_POLRVS = 5;
  localparam int SP_MDI = 4;
  localparam int SP_FORCE = 3;
  localparam int SP_PWRSAVE_OFF = 2;
  localparam int SP_RLOOP = 1;
  localparam logic SP_FORCE_RST = 1'b0;
  localparam logic SP_PWRSAVE_OFF_RST = 1'b1;
  localparam logic SP_RLOOP_RST = 1'b0;

  // interrupt status layout: diag done per port, then polarity change per port
  localparam int IRQ_W = 4;
  localparam int IRQ_DONE_LO = 0;
  localparam int IRQ_POL_LO = 2;
  localparam logic [3:0] IRQ_MASK_RST = 4'h0;

  // diagnostic timeout
  localparam int CLK_PERIOD_NS = 10;
  localparam int DIAG_TIMEOUT_US = 1000;
  localparam int DIAG_TIMEOUT_CYC = DIAG_TIMEOUT_US * 1000 / CLK_PERIOD_NS;

  typedef enum logic [1:0]
  {
    PDS_RES_NORMAL = 2'h0,
    PDS_RES_OPEN = 2'h1,
    PDS_RES_SHORT = 2'h2,
    PDS_RES_FAIL = 2'h3
  } pds_result_e;

  localparam pds_result_e CD_RES_RST = PDS_RES_NORMAL;

  typedef enum logic [1:0]
  {
    PDS_DG_IDLE = 2'b00,
    PDS_DG_RUN = 2'b01,
    PDS_DG_FINISH = 2'b11
  } pds_diag_state_e;

endpackage

// ### testbench/pds_phy_regs_monitor.sv
// concurrent checks on the ports of the PHY diagnostic register block
`timescale 1ns/1ns
`default_nettype none
module pds_phy_regs_monitor #(
  parameter int NUM_PORTS = 2,
  parameter int DIAG_TIMEOUT_CYC = 50
)
(
  input wire logic core_clk,
  input wire logic resetn,
  input wire logic [6:0] reg_addr,
  input wire logic [15:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [15:0] reg_rdata,
  input wire logic [NUM_PORTS*4-1:0] partner_ability_in,
  input wire logic [NUM_PORTS-1:0] polarity_reversed_in,
  input wire logic [NUM_PORTS-1:0] mdi_mode_in,
  input wire logic [NUM_PORTS-1:0] diag_ana_done,
  input wire logic [NUM_PORTS*2-1:0] diag_ana_result,
  input wire logic [NUM_PORTS-1:0] diag_ana_short,
  input wire logic [NUM_PORTS*9-1:0] diag_ana_count,
  input wire logic [NUM_PORTS-1:0] diag_ana_req,
  input wire logic [NUM_PORTS-1:0] force_link_pass,
  input wire logic [NUM_PORTS-1:0] power_save_en,
  input wire logic [NUM_PORTS-1:0] remote_loopback,
  input wire logic irq
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!resetn);

  rdata_idle_a: assert property (!reg_rd |=> reg_rdata == 16'h0000)
    else $error("read data not zero outside a read");
  unmapped_zero_a: assert property (
    reg_rd && reg_addr[6] && reg_addr[5:1] != 5'h00 |=> reg_rdata == 16'h0000)
    else $error("unmapped read not zero");
  pwrsave_ctl_a: assert property (
    reg_wr && reg_addr == 7'h1F |-> ##2 power_save_en[0] == !$past(reg_wdata[2], 2))
    else $error("power save output wrong after write");
  force_link_a: assert property (
    reg_wr && reg_addr == 7'h1F |-> ##2 force_link_pass[0] == $past(reg_wdata[3], 2))
    else $error("force link output wrong after write");
  loopback_p2_a: assert property (
    reg_wr && reg_addr == 7'h3F |-> ##2 remote_loopback[1] == $past(reg_wdata[1], 2))
    else $error("port two loopback wrong after write");
  lp_ability_a: assert property (
    reg_rd && reg_addr == 7'h05 && $stable(partner_ability_in[3:0])
    |=> reg_rdata == {7'h00, $past(partner_ability_in[3:0]), 5'h00})
    else $error("partner ability read wrong");
  polrvs_a: assert property (
    reg_rd && reg_addr == 7'h1F && $stable(polarity_reversed_in[0])
    |=> reg_rdata[5] == $past(polarity_reversed_in[0]) && reg_rdata[15:6] == 10'h000)
    else $error("polarity bit or reserved bits wrong");
  diag_resv_a: assert property (
    reg_rd && reg_addr == 7'h1D |=> reg_rdata[11:9] == 3'h0)
    else $error("diagnostic reserved bits not zero");
  req_rise_a: assert property (
    $rose(diag_ana_req[0]) |-> $past(reg_wr && reg_addr == 7'h1D && reg_wdata[15]))
    else $error("diagnostic started without a start write");
  req_done_a: assert property (
    diag_ana_req[0] && diag_ana_done[0] |=> !diag_ana_req[0])
    else $error("diagnostic request held after done");
  irq_fall_a: assert property (
    $fell(irq) |-> $past(reg_rd && reg_addr == 7'h40)
    || $past(reg_wr && reg_addr == 7'h41, 2))
    else $error("interrupt dropped without a status read");

  // cycles the port one request has been seen high without a break
  int req_run_cnt;
  always_ff @(posedge core_clk or negedge resetn)
  begin
    if (!resetn)
      req_run_cnt <= 0;
    else if (diag_ana_req[0])
      req_run_cnt <= req_run_cnt + 1;
    else
      req_run_cnt <= 0;
  end

  req_bound_a: assert property (req_run_cnt <= DIAG_TIMEOUT_CYC)
    else $error("diagnostic request outlived its timeout");
endmodule // pds_phy_regs_monitor

bind pds_phy_regs pds_phy_regs_monitor #(.NUM_PORTS(NUM_PORTS),
  .DIAG_TIMEOUT_CYC(DIAG_TIMEOUT_CYC)) u_mon (.core_clk(core_clk), .resetn(resetn),
  .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
  .reg_rdata(reg_rdata), .partner_ability_in(partner_ability_in),
  .polarity_reversed_in(polarity_reversed_in), .mdi_mode_in(mdi_mode_in),
  .diag_ana_done(diag_ana_done), .diag_ana_result(diag_ana_result),
  .diag_ana_short(diag_ana_short), .diag_ana_count(diag_ana_count),
  .diag_ana_req(diag_ana_req), .force_link_pass(force_link_pass),
  .power_save_en(power_save_en), .remote_loopback(remote_loopback), .irq(irq));
`default_nettype wire

// ### testbench/tb.sv
// self-checking bench for the PHY diagnostic and status register block
`timescale 1ns/1ns
`default_nettype none
module tb;
  logic core_clk = 1'b0;
  logic resetn = 1'b0;
  logic [6:0] reg_addr = 7'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  logic [7:0] partner_ability_in = 8'h00;
  logic [1:0] polarity_reversed_in = 2'h0;
  logic [1:0] mdi_mode_in = 2'h0;
  logic [1:0] diag_ana_done = 2'h0;
  logic [3:0] diag_ana_result = 4'h0;
  logic [1:0] diag_ana_short = 2'h0;
  logic [17:0] diag_ana_count = 18'h00000;
  logic [1:0] diag_ana_req, force_link_pass, power_save_en, remote_loopback;
  logic irq;
  logic [15:0] got;
  int fails = 0;
  int n_checks = 0;

  always #5 core_clk = ~core_clk;

  pds_phy_regs #(.NUM_PORTS(2), .DIAG_TIMEOUT_CYC(50)) dut (.core_clk(core_clk),
    .resetn(resetn), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_rdata(reg_rdata), .partner_ability_in(partner_ability_in),
    .polarity_reversed_in(polarity_reversed_in), .mdi_mode_in(mdi_mode_in),
    .diag_ana_done(diag_ana_done), .diag_ana_result(diag_ana_result),
    .diag_ana_short(diag_ana_short), .diag_ana_count(diag_ana_count),
    .diag_ana_req(diag_ana_req), .force_link_pass(force_link_pass),
    .power_save_en(power_save_en), .remote_loopback(remote_loopback), .irq(irq));

  task automatic stop_test;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask

  task automatic cmp16(input logic [15:0] g, input logic [15:0] e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: read %h expected %h", $time, g, e);
    end
  endtask

  task automatic cmp1(input logic g, input logic e);
    n_checks++;
    if (g !== e)
    begin
      fails++;
      $display("Error at %0t: flag %b expected %b", $time, g, e);
    end
  endtask

  task automatic wr(input logic [6:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  // read data stand only in the cycle after the strobe
  task automatic rd(input logic [6:0] a, output logic [15:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 d = reg_rdata;
  endtask

  task automatic rdchk(input logic [6:0] a, input logic [15:0] e);
    rd(a, got);
    cmp16(got, e);
  endtask

  // launch a test, optionally answer it, then poll until the start bit clears
  task automatic diag(input int p, input logic [1:0] r, input logic s, input logic [8:0] c,
    input logic answer);
    logic [6:0] a;
    a = (p == 1) ? 7'h3D : 7'h1D;
    wr(a, 16'h8000);
    #1 cmp1(diag_ana_req[p], 1'b1);
    if (answer)
    begin
      @(posedge core_clk);
      diag_ana_done[p] <= 1'b1;
      diag_ana_result[2*p +: 2] <= r;
      diag_ana_short[p] <= s;
      diag_ana_count[9*p +: 9] <= c;
      @(posedge core_clk);
      diag_ana_done[p] <= 1'b0;
      diag_ana_result[2*p +: 2] <= ~r;
      diag_ana_short[p] <= ~s;
      diag_ana_count[9*p +: 9] <= ~c;
    end
    for (int i = 0; i < 40; i++)
    begin
      rd(a, got);
      if (got[15] === 1'b0)
        break;
    end
    if (got[15] !== 1'b0)
    begin
      fails++;
      $display("Error at %0t: diagnostic never finished", $time);
      stop_test();
    end
    else
    begin
      cmp16(got, {1'b0, r, s, 3'h0, c});
      cmp1(diag_ana_req[p], 1'b0);
    end
  endtask

  initial
  begin
    repeat (4) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rdchk(7'h05, 16'h0000);
    rdchk(7'h1D, 16'h0000);
    rdchk(7'h3F, 16'h0004);
    cmp1(power_save_en[0], 1'b0);
    cmp1(force_link_pass[0], 1'b0);
    cmp1(remote_loopback[0], 1'b0);
    rdchk(7'h50, 16'h0000);
    rdchk(7'h40, 16'h0000);
    @(posedge core_clk);
    partner_ability_in <= 8'h5A;
    wr(7'h05, 16'hFFFF);
    rdchk(7'h05, 16'h0140);
    rdchk(7'h25, 16'h00A0);
    @(posedge core_clk);
    mdi_mode_in <= 2'h1;
    polarity_reversed_in <= 2'h2;
    wr(7'h1F, 16'hFFFF);
    rdchk(7'h1F, 16'h001E);
    cmp1(force_link_pass[0], 1'b1);
    cmp1(power_save_en[0], 1'b0);
    cmp1(remote_loopback[0], 1'b1);
    rdchk(7'h3F, 16'h0024);
    wr(7'h1F, 16'h0000);
    wr(7'h3F, 16'h0002);
    rdchk(7'h1F, 16'h0010);
    cmp1(power_save_en[0], 1'b1);
    cmp1(force_link_pass[0], 1'b0);
    cmp1(remote_loopback[1], 1'b1);
    // polarity change on port two left its event pending
    rdchk(7'h40, 16'h0008);
    wr(7'h41, 16'h0001);
    diag(0, 2'h2, 1'b1, 9'h1A5, 1'b1);
    cmp1(irq, 1'b1);
    rdchk(7'h40, 16'h0001);
    cmp1(irq, 1'b0);
    for (int k = 0; k < 4; k++)
      diag(1, 2'(k), k[0], 9'(9'h100 + k), 1'b1);
    cmp1(irq, 1'b0);
    diag(0, 2'h3, 1'b0, 9'h000, 1'b0);
    cmp1(irq, 1'b1);
    wr(7'h1D, 16'h7FFF);
    rdchk(7'h1D, 16'h6000);
    // reset after the timed-out run returns results and controls to their reset values
    @(posedge core_clk);
    resetn <= 1'b0;
    repeat (2) @(posedge core_clk);
    resetn <= 1'b1;
    @(posedge core_clk);
    rdchk(7'h1D, 16'h0000);
    rdchk(7'h3F, 16'h0024);
    cmp1(remote_loopback[1], 1'b0);
    cmp1(power_save_en[1], 1'b0);
    cmp1(irq, 1'b0);
    stop_test();
  end
endmodule // tb
`default_nettype wire
